// ===== src/ioab_buffers.v
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ioab_regs.vh"
module ioab_buffers #(
	parameter N_SYNC    = 4,
	parameter N_IN      = 2,
	parameter PULSE_CYC = `IOAB_READ_PULSE_CYC
) (
	// clock and reset
	input  wire                          hclk,
	input  wire                          hresetn,
	// ahb-lite slave
	input  wire                          hsel,
	input  wire [31:0]                   haddr,
	input  wire [1:0]                    htrans,
	input  wire                          hwrite,
	input  wire [2:0]                    hsize,
	input  wire [31:0]                   hwdata,
	input  wire                          hready,
	output reg                           hreadyout,
	output reg                           hresp,
	output reg  [31:0]                   hrdata,
	// synchronizer digit inputs, first and last half paths
	input  wire [N_IN*`IOAB_DIGIT_W-1:0] digit_input_amp_lo,
	input  wire [N_IN*`IOAB_DIGIT_W-1:0] digit_input_amp_hi,
	input  wire [N_IN*2*`IOAB_DIGITS-1:0] digit_write_select,
	output reg  [N_IN-1:0]               buffer_fill_select,
	// address readout toward the address-transfer logic
	output reg  [`IOAB_ADDR_W-1:0]       addr_reg_readout,
	output reg                           addr_readout_valid,
	// memory high-speed bus side
	output reg  [`IOAB_WORD_W-1:0]       memory_high_speed_bus,
	output reg                           buffer_readout_strobe
);

	localparam NBUF = 2 * N_IN;
	localparam DW   = `IOAB_DIGIT_W;
	localparam ND   = `IOAB_DIGITS;

	// ****************************************************************
	// phase generator
	// ****************************************************************
	reg phase;

	// one bit stands for the two-phase clock pair
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			phase <= `IOAB_PHASE_A;
		else
			phase <= ~phase;
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	reg  [7:0]                  ap_addr;
	reg                         ap_write;
	reg                         rd_wait;
	reg  [`IOAB_ADDR_W-1:0]     next_addr;
	reg  [N_SYNC-1:0]           rewrite_req;
	reg  [N_SYNC-1:0]           write_pend;
	reg  [`IOAB_ADDR_W-1:0]     last_readout;
	reg  [7:0]                  rd_index;
	reg                         mem_ready;
	reg  [7:0]                  pulse_cnt;
	reg  [`IOAB_WORD_W-1:0]     last_word;
	reg  [NBUF-1:0]             buf_full;
	wire                        ap_take;
	wire                        wr_do;
	wire                        busy;
	reg  [31:0]                 rd_mux;

	assign ap_take = hsel & htrans[1] & hready;
	assign wr_do   = ap_write & hreadyout;
	assign busy    = mem_ready | buffer_readout_strobe;

	// read data multiplexer, unmapped reads give zero
	always @* begin
		rd_mux = 32'h00000000;
		case (ap_addr)
			`IOAB_OFF_NEXT_ADDR:  rd_mux[`IOAB_ADDR_W-1:0] = next_addr;
			`IOAB_OFF_REWRITE:    rd_mux[N_SYNC-1:0] = rewrite_req | write_pend;
			`IOAB_OFF_READOUT:    rd_mux[`IOAB_ADDR_W-1:0] = last_readout;
			`IOAB_OFF_BUF_READ: begin
				rd_mux[7:0] = rd_index;
				rd_mux[`IOAB_BUSY_BIT] = busy;
			end
			`IOAB_OFF_BUF_STATUS: begin
				rd_mux[NBUF-1:0] = buf_full;
				rd_mux[`IOAB_FILL_SEL_POS+N_IN-1:`IOAB_FILL_SEL_POS] = buffer_fill_select;
			end
			`IOAB_OFF_WORD_LO:    rd_mux = last_word[31:0];
			`IOAB_OFF_WORD_HI:    rd_mux[`IOAB_WORD_W-33:0] = last_word[`IOAB_WORD_W-1:32];
			default:              rd_mux = 32'h00000000;
		endcase
	end

	// reads take one wait state so a write just before is seen
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_addr   <= 8'h00;
			ap_write  <= 1'b0;
			rd_wait   <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			if (rd_wait) begin
				hrdata    <= rd_mux;
				hreadyout <= 1'b1;
				rd_wait   <= 1'b0;
				ap_write  <= 1'b0;
			end else if (ap_take) begin
				ap_addr  <= {haddr[7:2], 2'b00};
				ap_write <= hwrite;
				if (!hwrite) begin
					rd_wait   <= 1'b1;
					hreadyout <= 1'b0;
				end
			end else begin
				ap_write <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// address registers
	// ****************************************************************
	reg  [N_SYNC*`IOAB_ADDR_W-1:0] addr_store;
	reg  [`IOAB_ADDR_W-1:0]        rd_or;
	integer                        j;
	integer                        jw;

	// series-wired outputs: any registers read together are or-ed
	always @* begin
		rd_or = `IOAB_RST_ADDR;
		for (j = 0; j < N_SYNC; j = j + 1)
			if (rewrite_req[j])
				rd_or = rd_or | addr_store[j*`IOAB_ADDR_W +: `IOAB_ADDR_W];
	end

	// read on phase A clears and arms the write; write on phase B
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_store         <= {N_SYNC*`IOAB_ADDR_W{1'b0}};
			next_addr          <= `IOAB_RST_ADDR;
			rewrite_req        <= {N_SYNC{1'b0}};
			write_pend         <= {N_SYNC{1'b0}};
			last_readout       <= `IOAB_RST_ADDR;
			addr_reg_readout   <= `IOAB_RST_ADDR;
			addr_readout_valid <= 1'b0;
		end else begin
			addr_readout_valid <= 1'b0;
			if (wr_do && ap_addr == `IOAB_OFF_NEXT_ADDR)
				next_addr <= hwdata[`IOAB_ADDR_W-1:0];
			if (phase == `IOAB_PHASE_A && rewrite_req != {N_SYNC{1'b0}}) begin
				addr_reg_readout   <= rd_or;
				last_readout       <= rd_or;
				addr_readout_valid <= 1'b1;
				write_pend         <= rewrite_req;
				for (jw = 0; jw < N_SYNC; jw = jw + 1)
					if (rewrite_req[jw])
						addr_store[jw*`IOAB_ADDR_W +: `IOAB_ADDR_W] <= `IOAB_RST_ADDR;
				// a request arriving now waits for the next phase A
				rewrite_req <= (wr_do && ap_addr == `IOAB_OFF_REWRITE) ?
					hwdata[N_SYNC-1:0] : {N_SYNC{1'b0}};
			end else begin
				if (wr_do && ap_addr == `IOAB_OFF_REWRITE)
					rewrite_req <= rewrite_req | hwdata[N_SYNC-1:0];
				if (phase == `IOAB_PHASE_B) begin
					for (jw = 0; jw < N_SYNC; jw = jw + 1)
						if (write_pend[jw])
							addr_store[jw*`IOAB_ADDR_W +: `IOAB_ADDR_W] <=
								addr_store[jw*`IOAB_ADDR_W +: `IOAB_ADDR_W] | next_addr;
					write_pend <= {N_SYNC{1'b0}};
				end
			end
		end
	end

	// ****************************************************************
	// input buffers
	// ****************************************************************
	reg  [NBUF*`IOAB_WORD_W-1:0] ibuf;
	reg  [NBUF*ND-1:0]           digit_done;
	reg  [N_IN*2*ND-1:0]         held_sel;
	reg  [N_IN*DW-1:0]           held_lo;
	reg  [N_IN*DW-1:0]           held_hi;
	integer                      b;
	integer                      d;
	integer                      s;
	integer                      bf;

	// strobes seen on phase A are held and stored at the next phase B
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			held_sel <= {N_IN*2*ND{1'b0}};
			held_lo  <= {N_IN*DW{1'b0}};
			held_hi  <= {N_IN*DW{1'b0}};
		end else if (phase == `IOAB_PHASE_A) begin
			held_sel <= digit_write_select;
			held_lo  <= digit_input_amp_lo;
			held_hi  <= digit_input_amp_hi;
		end else begin
			held_sel <= {N_IN*2*ND{1'b0}};
		end
	end

	// digit writes on phase B, whole-word readout on phase A
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ibuf       <= {NBUF*`IOAB_WORD_W{1'b0}};
			digit_done <= {NBUF*ND{1'b0}};
		end else if (phase == `IOAB_PHASE_B) begin
			for (b = 0; b < NBUF; b = b + 1) begin // both buffers of a sync share inputs
				for (d = 0; d < ND; d = d + 1) begin
					if (digit_write_select[b*ND+d]) begin
						digit_done[b*ND+d] <= 1'b1;
						ibuf[b*`IOAB_WORD_W+d*DW +: DW] <= ibuf[b*`IOAB_WORD_W+d*DW +: DW] |
							((d < `IOAB_HALF_DIGITS) ? digit_input_amp_lo[(b / 2)*DW +: DW]
								: digit_input_amp_hi[(b / 2)*DW +: DW]);
					end else if (held_sel[b*ND+d]) begin
						digit_done[b*ND+d] <= 1'b1;
						ibuf[b*`IOAB_WORD_W+d*DW +: DW] <= ibuf[b*`IOAB_WORD_W+d*DW +: DW] |
							((d < `IOAB_HALF_DIGITS) ? held_lo[(b / 2)*DW +: DW]
								: held_hi[(b / 2)*DW +: DW]);
					end
				end
			end
		end else if (mem_ready && rd_index < NBUF) begin
			// both halves cleared at once, even if still filling
			ibuf[rd_index*`IOAB_WORD_W +: `IOAB_WORD_W] <= `IOAB_RST_WORD;
			digit_done[rd_index*ND +: ND] <= {ND{1'b0}};
		end
	end

	// full flags per buffer for status and role swap
	always @* begin
		for (bf = 0; bf < NBUF; bf = bf + 1)
			buf_full[bf] = &digit_done[bf*ND +: ND];
	end

	// swap fill role once the filling buffer is full and the other empty
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			buffer_fill_select <= {N_IN{1'b0}};
		else
			for (s = 0; s < N_IN; s = s + 1)
				if (buf_full[2*s + buffer_fill_select[s]] &&
					digit_done[(2*s + 1 - buffer_fill_select[s])*ND +: ND] == {ND{1'b0}})
					buffer_fill_select[s] <= ~buffer_fill_select[s];
	end

	// ****************************************************************
	// readout toward memory
	// ****************************************************************
	// a single flag serialises all readouts onto the one shared path
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_index              <= 8'h00;
			mem_ready             <= 1'b0;
			pulse_cnt             <= 8'h00;
			last_word             <= `IOAB_RST_WORD;
			memory_high_speed_bus <= `IOAB_RST_WORD;
			buffer_readout_strobe <= 1'b0;
		end else begin
			if (wr_do && ap_addr == `IOAB_OFF_BUF_READ && !busy) begin
				rd_index  <= hwdata[7:0];
				mem_ready <= 1'b1;
			end
			if (mem_ready && phase == `IOAB_PHASE_A) begin
				mem_ready             <= 1'b0;
				buffer_readout_strobe <= 1'b1;
				pulse_cnt             <= PULSE_CYC[7:0] - 8'h01;
				if (rd_index < NBUF) begin
					memory_high_speed_bus <= ibuf[rd_index*`IOAB_WORD_W +: `IOAB_WORD_W];
					last_word             <= ibuf[rd_index*`IOAB_WORD_W +: `IOAB_WORD_W];
				end else begin
					memory_high_speed_bus <= `IOAB_RST_WORD;
					last_word             <= `IOAB_RST_WORD;
				end
			end else if (buffer_readout_strobe) begin
				if (pulse_cnt == 8'h00)
					buffer_readout_strobe <= 1'b0;
				else
					pulse_cnt <= pulse_cnt - 8'h01;
			end
		end
	end

endmodule // ioab_buffers

// ===== src/ioab_regs.vh
`ifndef IOAB_REGS_VH
`define IOAB_REGS_VH

// ****************************************************************
// register offsets (byte addresses on the bus)
// ****************************************************************
`define IOAB_OFF_NEXT_ADDR   8'h00
`define IOAB_OFF_REWRITE     8'h04
`define IOAB_OFF_READOUT     8'h08
`define IOAB_OFF_BUF_READ    8'h0c
`define IOAB_OFF_BUF_STATUS  8'h10
`define IOAB_OFF_WORD_LO     8'h14
`define IOAB_OFF_WORD_HI     8'h18

// ****************************************************************
// field positions and widths
// ****************************************************************
`define IOAB_ADDR_W          25
`define IOAB_DIGIT_W         5
`define IOAB_DIGITS          12
`define IOAB_WORD_W          60
`define IOAB_HALF_DIGITS     6
`define IOAB_BUSY_BIT        31
`define IOAB_FILL_SEL_POS    16

// ****************************************************************
// reset values and phase encoding
// ****************************************************************
`define IOAB_RST_ADDR        25'h0000000
`define IOAB_RST_WORD        60'h000000000000000
`define IOAB_PHASE_A         1'b0
`define IOAB_PHASE_B         1'b1

// ****************************************************************
// timing
// ****************************************************************
`define IOAB_CLK_NS          10
`define IOAB_READ_PULSE_NS   1000
`define IOAB_READ_PULSE_CYC  ((`IOAB_READ_PULSE_NS + `IOAB_CLK_NS - 1) / `IOAB_CLK_NS)

`endif

// ===== test/ioab_checker.sv
`timescale 1ns/1ps
// ********************
// port protocol checks
// ********************
module ioab_checker #(
	parameter PULSE_CYC = 4
) (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	// register bus
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	// address and word outputs
	input wire [24:0] addr_reg_readout,
	input wire        addr_readout_valid,
	input wire [59:0] memory_high_speed_bus,
	input wire        buffer_readout_strobe
);
	logic [15:0] hi_cnt;
	wire         rd_req = hsel & htrans[1] & hready & !hwrite;
	wire         wr_req = hsel & htrans[1] & hready & hwrite;

	// length of the current readout pulse, cheaper than a long repetition
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hi_cnt <= 16'h0000;
		else
			hi_cnt <= buffer_readout_strobe ? hi_cnt + 16'h0001 : 16'h0000;
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus answered with an error");
	a_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
		else $error("read did not take one wait state");
	a_write_nowait: assert property (wr_req |=> hreadyout)
		else $error("write was stalled");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	a_pulse_len: assert property ($fell(buffer_readout_strobe) |-> hi_cnt == PULSE_CYC)
		else $error("readout pulse has the wrong length");
	a_pulse_max: assert property (hi_cnt <= PULSE_CYC)
		else $error("readout pulse too long");
	a_bus_hold: assert property (!$rose(buffer_readout_strobe) |-> $stable(memory_high_speed_bus))
		else $error("memory bus moved without a readout");
	a_valid_pulse: assert property (addr_readout_valid |=> !addr_readout_valid)
		else $error("address readout pulse too long");
	a_readout_hold: assert property ($changed(addr_reg_readout) |-> addr_readout_valid)
		else $error("address readout moved without a pulse");
endmodule // ioab_checker

// ===== test/ioab_sync_model.sv
`timescale 1ns/1ps
// ********************
// synchronizer digit source
// ********************
module ioab_sync_model (
	// clock
	input  wire         hclk,
	// digit link of one synchronizer
	output logic [4:0]  dig_lo,
	output logic [4:0]  dig_hi,
	output logic [23:0] sel
);
	// lines idle at an arbitrary level
	initial begin
		dig_lo = 5'h15;
		dig_hi = 5'h0a;
		sel = 24'h000000;
	end

	// one digit per two cycles so a phase-a strobe still finds its data
	task automatic fill(input logic k, input logic [59:0] w, input logic rev);
		int d;
		for (int i = 0; i < 12; i++) begin
			d = rev ? 11 - i : i;
			@(posedge hclk);
			if (d < 6)
				dig_lo <= w[d*5 +: 5];
			else
				dig_hi <= w[d*5 +: 5];
			sel <= 24'h000001 << (12 * k + d);
			@(posedge hclk);
			sel <= 24'h000000;
		end
		// released lines show the inverse, never a stale digit
		@(posedge hclk);
		dig_lo <= ~dig_lo;
		dig_hi <= ~dig_hi;
	endtask
endmodule // ioab_sync_model

// ===== test/io_address_and_input_buffers_bench.sv
`timescale 1ns/1ps
`include "ioab_regs.vh"
// ********************
// self-checking bench
// ********************
module io_address_and_input_buffers_bench;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rdv, x;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hreadyout, hresp, addr_readout_valid, buffer_readout_strobe;
	wire  [31:0] hrdata;
	wire  [24:0] addr_reg_readout;
	wire  [59:0] memory_high_speed_bus;
	wire  [1:0]  buffer_fill_select;
	wire  [4:0]  lo0, lo1, hi0, hi1;
	wire  [23:0] sel0, sel1;
	logic [31:0] seed = 32'h7cab;
	logic [24:0] ea [4] = '{4{25'h0}};
	logic [59:0] w [2][2];
	logic        k [2];
	int          error_cnt = 0, n_tests = 0, r, s;

	ioab_buffers #(.PULSE_CYC(4)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.digit_input_amp_lo({lo1, lo0}), .digit_input_amp_hi({hi1, hi0}),
		.digit_write_select({sel1, sel0}), .buffer_fill_select(buffer_fill_select),
		.addr_reg_readout(addr_reg_readout), .addr_readout_valid(addr_readout_valid),
		.memory_high_speed_bus(memory_high_speed_bus),
		.buffer_readout_strobe(buffer_readout_strobe));
	ioab_sync_model sy0 (.hclk(hclk), .dig_lo(lo0), .dig_hi(hi0), .sel(sel0));
	ioab_sync_model sy1 (.hclk(hclk), .dig_lo(lo1), .dig_hi(hi1), .sel(sel1));

	// clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (5000) @(posedge hclk);
		error_cnt++;
		give_verdict();
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [59:0] g, input logic [59:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	// one single transfer; waits as long as the slave stalls
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	// expected readout is the or of every selected old address
	task automatic rewrite(input logic [3:0] m, input logic [24:0] a);
		logic [24:0] e;
		e = 25'h0;
		for (int i = 0; i < 4; i++)
			e |= m[i] ? ea[i] : 25'h0;
		ahb(1'b1, `IOAB_OFF_NEXT_ADDR, {7'h00, a});
		ahb(1'b1, `IOAB_OFF_REWRITE, {28'h0000000, m});
		do @(negedge hclk); while (addr_readout_valid !== 1'b1);
		chk(addr_reg_readout, e);
		@(posedge hclk);
		for (int i = 0; i < 4; i++)
			ea[i] = m[i] ? a : ea[i];
		ahb(1'b0, `IOAB_OFF_READOUT, 32'h0);
		chk(rdv[24:0], e);
	endtask

	// readout, plus a second request while busy that must be ignored
	task automatic drain(input logic [7:0] i, input logic [59:0] e);
		ahb(1'b1, `IOAB_OFF_BUF_READ, {24'h000000, i});
		do @(negedge hclk); while (buffer_readout_strobe !== 1'b1);
		chk(memory_high_speed_bus, e);
		@(posedge hclk);
		ahb(1'b1, `IOAB_OFF_BUF_READ, 32'h00000003);
		ahb(1'b0, `IOAB_OFF_WORD_LO, 32'h0);
		x = rdv;
		ahb(1'b0, `IOAB_OFF_WORD_HI, 32'h0);
		chk({rdv[27:0], x}, e);
		do ahb(1'b0, `IOAB_OFF_BUF_READ, 32'h0); while (rdv[31] !== 1'b0);
	endtask

	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (r = 0; r < 12; r++) begin
			x = rnd();
			rewrite(r < 4 ? 4'(1 << r) : x[28:25] | 4'h1, x[24:0]);
		end
		for (s = 0; s < 2; s++)
			k[s] = buffer_fill_select[s];
		// both synchronizers fill at once, opposite digit orders
		for (r = 0; r < 2; r++) begin
			for (s = 0; s < 2; s++) begin
				x = rnd();
				w[s][r] = {x[27:0], rnd()};
			end
			fork
				sy0.fill(k[0] ^ r[0], w[0][r], 1'b0);
				sy1.fill(k[1] ^ r[0], w[1][r], 1'b1);
			join
			repeat (4) @(negedge hclk);
			for (s = 0; s < 2; s++)
				chk(buffer_fill_select[s], !k[s]);
		end
		@(posedge hclk);
		ahb(1'b0, `IOAB_OFF_BUF_STATUS, 32'h0);
		chk(rdv[3:0], 4'hf);
		for (s = 0; s < 2; s++) begin
			drain(8'(2 * s + k[s]), w[s][0]);
			repeat (4) @(negedge hclk);
			chk(buffer_fill_select[s], k[s]);
			@(posedge hclk);
			drain(8'(2 * s + !k[s]), w[s][1]);
		end
		drain(8'h07, 60'h0);
		ahb(1'b0, `IOAB_OFF_BUF_STATUS, 32'h0);
		chk(rdv[3:0], 4'h0);
		give_verdict();
	end
endmodule // io_address_and_input_buffers_bench

bind ioab_buffers ioab_checker #(.PULSE_CYC(PULSE_CYC)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.addr_reg_readout(addr_reg_readout), .addr_readout_valid(addr_readout_valid),
	.memory_high_speed_bus(memory_high_speed_bus),
	.buffer_readout_strobe(buffer_readout_strobe));
